// File: logic/srs_debounce.sv
// Manual reset input synchroniser and qualifier.
module srs_debounce
    import srs_pkg::*;
#(
    parameter int QUAL_CYC  = MAN_QUAL_CYC,
    parameter int DELAY_CYC = MAN_DELAY_CYC
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic manual_reset_n,
    output logic      manual_active
);
    localparam int W = $clog2(QUAL_CYC + DELAY_CYC + 2);
    localparam logic [W-1:0] TRIP = W'(QUAL_CYC + DELAY_CYC);

    logic         sync1_reg;
    logic         sync2_reg;
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         act_reg;
    logic         act_next;

    // =========================================================
    // Qualify low level, then delay assertion
    always_comb begin
        cnt_next = cnt_reg;
        act_next = act_reg;
        if (sync2_reg) begin
            cnt_next = '0;
            act_next = 1'b0;
        end else if (cnt_reg >= TRIP) begin
            act_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg   <= '0;
            act_reg   <= 1'b0;
        end else begin
            sync1_reg <= manual_reset_n;
            sync2_reg <= sync1_reg;
            cnt_reg   <= cnt_next;
            act_reg   <= act_next;
        end
    end

    assign manual_active = act_reg;

    AST_MAN_GLITCH: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(act_reg) |-> $past(cnt_reg) == TRIP)
        else $error("Manual reset asserted before qualification.");
    AST_MAN_RELEASE: assert property (@(posedge mclk) disable iff (!rst_b)
        sync2_reg |=> !act_reg)
        else $error("Manual reset stayed active after input high.");
endmodule

// File: logic/srs_pkg.sv
// Constants and types shared by the supply reset supervisor.
// Notes on behaviour
// - Reset asserted while supply is low.
// - Hold reset one timeout after supply recovers.
// - Reset polarity chosen at build time.
// - Manual low 25 us then 12 us delay.
// - Debounce manual input; open input reads high.
// - Manual low holds reset, then timeout release.
// - Warning output low while low-line indicated.
// - Any kick edge restarts the watchdog counter.
// - No kick within timeout forces reset.
// - Watchdog timeout is one of four constants.
package srs_pkg;
    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 4;
    localparam int MAN_QUAL_NS       = 25000;
    localparam int MAN_DELAY_NS      = 12000;
    localparam int MAN_QUAL_CYC      = (MAN_QUAL_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
    localparam int MAN_DELAY_CYC     = MAN_DELAY_NS / CLK_PERIOD_NS;
    localparam int RESET_TIMEOUT_US  = 200;
    localparam int RESET_TIMEOUT_CYC = RESET_TIMEOUT_US * 1000
                                       / CLK_PERIOD_NS;
    localparam longint WD_OPT0_US    = 64'd6200;
    localparam longint WD_OPT1_US    = 64'd102000;
    localparam longint WD_OPT2_US    = 64'd1600000;
    localparam longint WD_OPT3_US    = 64'd25600000;
    localparam int CNT_W             = 34;
    localparam int SEL_W             = 2;

    // =========================================================
    // Supervisor states
    typedef enum logic [2:0] {
        SRS_HOLD = 3'b001,
        SRS_RUN  = 3'b010,
        SRS_WDOG = 3'b100
    } srs_state_t;

    function automatic logic [CNT_W-1:0] srs_wd_cycles(
        input logic [SEL_W-1:0] sel
    );
        longint us;
        us = WD_OPT0_US;
        case (sel)
            2'h1:    us = WD_OPT1_US;
            2'h2:    us = WD_OPT2_US;
            2'h3:    us = WD_OPT3_US;
            default: us = WD_OPT0_US;
        endcase
        return CNT_W'(us * 1000 / CLK_PERIOD_NS);
    endfunction
endpackage

// File: logic/srs_supervisor.sv
// Top of the supply reset supervisor with watchdog.
module srs_supervisor
    import srs_pkg::*;
#(
    parameter bit             RESET_ACTIVE_HIGH = 1'b0,
    parameter logic [SEL_W-1:0] WD_SEL          = 2'h0,
    parameter int             RESET_CYC         = RESET_TIMEOUT_CYC,
    parameter int             MAN_QUAL          = MAN_QUAL_CYC,
    parameter int             MAN_DELAY         = MAN_DELAY_CYC,
    parameter logic [CNT_W-1:0] WD_CYC          = srs_wd_cycles(WD_SEL)
) (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic supply_low,
    input  wire logic low_line,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick_in,
    output logic      cpu_reset,
    output logic      low_line_warn_n
);
    localparam logic [CNT_W-1:0] RST_LAST = CNT_W'(RESET_CYC - 1);
    localparam logic [CNT_W-1:0] WD_LAST  = WD_CYC - CNT_W'(1);

    logic             manual_active;
    logic             sl1_reg;
    logic             sl2_reg;
    logic             ll1_reg;
    logic             ll2_reg;
    logic             wk1_reg;
    logic             wk2_reg;
    logic             wk3_reg;
    srs_state_t       state_reg;
    srs_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             rst_reg;
    logic             rst_next;
    logic             warn_reg;
    logic             kick;
    logic             cause;

    srs_debounce #(
        .QUAL_CYC  (MAN_QUAL),
        .DELAY_CYC (MAN_DELAY)
    ) u_debounce (
        .mclk           (mclk),
        .rst_b          (rst_b),
        .manual_reset_n (manual_reset_n),
        .manual_active  (manual_active)
    );

    // =========================================================
    // Pin synchronisers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sl1_reg <= 1'b1;
            sl2_reg <= 1'b1;
            ll1_reg <= 1'b0;
            ll2_reg <= 1'b0;
            wk1_reg <= 1'b0;
            wk2_reg <= 1'b0;
            wk3_reg <= 1'b0;
        end else begin
            sl1_reg <= supply_low;
            sl2_reg <= sl1_reg;
            ll1_reg <= low_line;
            ll2_reg <= ll1_reg;
            wk1_reg <= watchdog_kick_in;
            wk2_reg <= wk1_reg;
            wk3_reg <= wk2_reg;
        end
    end

    assign kick  = wk2_reg ^ wk3_reg;
    assign cause = sl2_reg | manual_active;

    // =========================================================
    // Reset sequencer and watchdog
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rst_next   = 1'b1;
        unique case (state_reg)
            SRS_HOLD, SRS_WDOG: begin
                if (cause) begin
                    state_next = SRS_HOLD;
                    cnt_next   = '0;
                end else if (cnt_reg >= RST_LAST) begin
                    state_next = SRS_RUN;
                    cnt_next   = '0;
                    rst_next   = 1'b0;
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
            SRS_RUN: begin
                rst_next = 1'b0;
                if (cause) begin
                    state_next = SRS_HOLD;
                    cnt_next   = '0;
                    rst_next   = 1'b1;
                end else if (kick) begin
                    cnt_next = '0;
                end else if (cnt_reg >= WD_LAST) begin
                    state_next = SRS_WDOG;
                    cnt_next   = '0;
                    rst_next   = 1'b1;
                end else begin
                    cnt_next = cnt_reg + CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= SRS_HOLD;
            cnt_reg   <= '0;
            rst_reg   <= 1'b1;
            warn_reg  <= 1'b1;
            cpu_reset <= RESET_ACTIVE_HIGH;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rst_reg   <= rst_next;
            warn_reg  <= !ll2_reg;
            cpu_reset <= rst_next ~^ RESET_ACTIVE_HIGH;
        end
    end

    assign low_line_warn_n = warn_reg;

    // =========================================================
    // Checks
    AST_SUPPLY_RESET: assert property (@(posedge mclk) disable iff (!rst_b)
        sl2_reg |=> rst_reg)
        else $error("Supply low did not assert reset.");
    AST_HOLD_TIME: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(rst_reg) |-> $past(cnt_reg) >= RST_LAST)
        else $error("Reset released before timeout.");
    AST_POLARITY: assert property (@(posedge mclk) disable iff (!rst_b)
        cpu_reset == (rst_reg ~^ RESET_ACTIVE_HIGH))
        else $error("Reset output polarity wrong.");
    AST_MANUAL_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
        manual_active |=> rst_reg)
        else $error("Manual reset did not hold reset.");
    AST_WARN: assert property (@(posedge mclk) disable iff (!rst_b)
        ll2_reg |=> !low_line_warn_n)
        else $error("Low-line warning not driven low.");
    AST_KICK: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_reg == SRS_RUN && kick && !cause) |=> cnt_reg == '0)
        else $error("Kick did not restart watchdog.");
    AST_WD_FIRE: assert property (@(posedge mclk) disable iff (!rst_b)
        (state_reg == SRS_RUN && !kick && !cause && cnt_reg >= WD_LAST)
        |=> state_reg == SRS_WDOG && rst_reg)
        else $error("Watchdog expiry did not force reset.");
    AST_WD_RESTART: assert property (@(posedge mclk) disable iff (!rst_b)
        ($past(state_reg) == SRS_WDOG && state_reg == SRS_RUN)
        |-> cnt_reg == '0)
        else $error("Watchdog did not restart from zero.");
    AST_WD_SPAN: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == SRS_RUN |-> cnt_reg <= WD_LAST)
        else $error("Watchdog count exceeded timeout.");
endmodule

// File: test/srs_cpu_model.sv
// Processor model that toggles the watchdog line while it runs.
module srs_cpu_model #(
    parameter int KICK_CYC = 30
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic hung,
    output logic      watchdog_kick_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial watchdog_kick_in = 1'b0;
    // A processor in reset or stuck in a loop stops toggling.
    always @(posedge mclk) begin
        if (reset_n !== 1'b1 || hung) begin
            cnt <= 0;
        end else if (cnt == KICK_CYC - 1) begin
            cnt <= 0;
            watchdog_kick_in <= ~watchdog_kick_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// File: test/srs_supervisor_tb.sv
// Self-checking bench for the supply reset supervisor.
module srs_supervisor_tb;
    import srs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RC = 20;
    localparam int WC = 100;
    logic mclk = 1'b0, rst_b = 1'b0, supply_low = 1'b0, low_line = 1'b0;
    logic manual_reset_n = 1'b1, hung = 1'b0;
    logic cpu_reset, low_line_warn_n, watchdog_kick_in;
    int   bad_count = 0, comparisons = 0, seed = 20, cycles = 0, i, n;
    always #2 mclk = ~mclk;
    srs_supervisor #(.RESET_CYC(RC), .MAN_QUAL(10), .MAN_DELAY(5),
        .WD_CYC(CNT_W'(WC))) DUT (.mclk(mclk), .rst_b(rst_b),
        .supply_low(supply_low), .low_line(low_line),
        .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(watchdog_kick_in), .cpu_reset(cpu_reset),
        .low_line_warn_n(low_line_warn_n));
    srs_cpu_model #(.KICK_CYC(30)) CPU (.mclk(mclk), .reset_n(cpu_reset),
        .hung(hung), .watchdog_kick_in(watchdog_kick_in));
    // =========================================================
    // Helpers
    function automatic logic lvl(input bit on);
        return on ? 1'b0 : 1'b1;
    endfunction
    task automatic check(input logic got, input logic exp, input string m);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic wait_rst(input bit on, input int max);
        n = 0;
        while (cpu_reset !== lvl(on) && n < max) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(cpu_reset, lvl(on), "reset level late");
    endtask
    task automatic hold_rst(input bit on, input int len);
        logic ok;
        ok = 1'b1;
        repeat (len) begin
            @(posedge mclk);
            #1;
            if (cpu_reset !== lvl(on)) ok = 1'b0;
        end
        check(ok, 1'b1, "reset level changed");
    endtask
    task automatic print_verdict;
        $display("Counts: %0d mismatches, %0d comparisons",
                 bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("MISMATCH %0t run took too long", $time);
            print_verdict;
        end
    end
    // =========================================================
    // Scenarios
    initial begin
        step(4);
        rst_b <= 1'b1;
        hold_rst(1, RC - 1);
        wait_rst(0, 10);
        for (i = 0; i < 3; i++) begin
            @(posedge mclk);
            supply_low <= 1'b1;
            wait_rst(1, 4);
            hold_rst(1, 5 + $unsigned($random(seed)) % 40);
            @(posedge mclk);
            supply_low <= 1'b0;
            hold_rst(1, RC);
            wait_rst(0, 8);
        end
        @(posedge mclk);
        low_line <= 1'b1;
        step(4);
        #1 check(low_line_warn_n, 1'b0, "warning not low");
        check(cpu_reset, lvl(0), "warning caused reset");
        @(posedge mclk);
        low_line <= 1'b0;
        step(4);
        #1 check(low_line_warn_n, 1'b1, "warning stuck low");
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            manual_reset_n <= 1'b0;
            step(1 + $unsigned($random(seed)) % 9);
            manual_reset_n <= 1'b1;
            hold_rst(0, 30);
        end
        @(posedge mclk);
        manual_reset_n <= 1'b0;
        hold_rst(0, 12);
        wait_rst(1, 15);
        hold_rst(1, 40);
        @(posedge mclk);
        manual_reset_n <= 1'b1;
        hold_rst(1, RC);
        wait_rst(0, 8);
        hold_rst(0, 2 * WC);
        @(posedge mclk);
        hung <= 1'b1;
        hold_rst(0, WC - 40);
        wait_rst(1, 50);
        hold_rst(1, RC - 2);
        wait_rst(0, 8);
        hold_rst(0, WC - 10);
        wait_rst(1, 20);
        @(posedge mclk);
        hung <= 1'b0;
        wait_rst(0, RC + 8);
        print_verdict;
    end
endmodule
